// File: src/eeprom_map.svh
// Constants for the two-wire EEPROM slave front end
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
// Upper address nibble the device answers to; arbitrary value
`define CLASS_ID 4'h5
// Array and page geometry
`define ADDR_W 8
`define PAGE_W 4
`define DATA_W 8
// Bit count at which the acknowledge slot starts
`define ACK_SLOT 4'h8
// Internal write cycle time in microseconds and derived clk cycles
`define WRITE_US 5000
`define WRITE_CYC (`WRITE_US * 100)
`endif

// File: src/eeprom_pkg.sv
// Types shared by the EEPROM slave files
package eeprom_pkg;
  // Byte-level protocol phases on the link side
  typedef enum logic [2:0] {
    IDLE,
    DEV_ADDR,
    WORD_ADDR,
    WR_DATA,
    RD_DATA,
    IGNORE
  } phase_t;
  typedef logic [7:0] byte_t;
endpackage

// File: src/mem_if.sv
// Interface between slave logic and the byte memory
interface mem_if;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  // Slave side drives addresses and write strobe
  modport ctrl (output wrEn, output wrAddr, output wrData,
                output rdAddr, input rdData);
  // Memory side returns registered read data
  modport mem (input wrEn, input wrAddr, input wrData,
               input rdAddr, output rdData);
endinterface

// File: src/byte_mem.sv
// Small byte memory with registered read data
module byte_mem (
  // Clock
  input wire logic clk,
  // Access port
  mem_if.mem port
);
  // Storage, no reset so it maps to RAM
  logic [7:0] store [0:255];
  logic [7:0] rdData_r;

  // Write and registered read
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
    rdData_r <= store[port.rdAddr];
  end
  assign port.rdData = rdData_r;
endmodule

// File: src/serial_eeprom_i2c_slave.sv
// Two-wire EEPROM slave: bus front end, page buffer and write timer
//
// Overview of operation
// [R01] Data falls while clock high: start
// [R02] Data rises while clock high: stop
// [R03] Master opens each command with start
// [R04] Bytes shift most significant bit first
// [R05] Data changes only while clock low
// [R06] One clock per bit, unbounded bytes
// [R07] Receiver acknowledges during ninth clock
// [R08] No acknowledge while write cycle busy
// [R09] Read: release, sample ack, send next
// [R10] Read nack: stop sending, await stop
// [R11] Upper address nibble must match class
// [R12] Bits b3..b1 match high, mid, low straps
// [R13] Bit b0 one reads, zero writes
// [R14] Floating straps read as low
// [R15] Protect high disables all array writes
// [R16] Floating protect input reads low
// [R17] Page buffer holds sixteen bytes
// [R18] Word address auto increments over 256
// [R19] Master starts only on idle bus
// [R20] Handles 100 kHz and 400 kHz clocks
// [R21] Only master drives serial clock
// [R22] Stop after write launches array cycle
// [R23] Protected: ack addresses, nack data
// [R24] Over sixteen bytes wraps in page
// [R25] Word address holds last plus one
// [R26] Address mismatch: stay off until start
// [R27] Mid-byte start or stop aborts transfer
`include "eeprom_map.svh"
module serial_eeprom_i2c_slave #(
  parameter int WRITE_CYCLES = `WRITE_CYC
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link clock pin, clocks the bus-side logic
  input wire logic sclClk,
  // Data pin, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Straps, pulled low outside the device
  input wire logic select_strap_low,
  input wire logic select_strap_mid,
  input wire logic select_strap_high,
  input wire logic writeProtect,
  // Busy status
  output logic writeBusy
);
  // ---------------------------------------------------------------
  // Start and stop detection
  // ---------------------------------------------------------------
  // Sampled on data edges; a condition needs the clock pin high.
  // Each flag toggles on its own condition; only rst_n clears it.
  logic startTgl_r, stopTgl_r;
  logic startSeen_r, startAck_r, startAck2_r;
  // [R01] Start on falling data with clock high
  always_ff @(negedge sdaIn or negedge rst_n) begin
    if (!rst_n) begin
      startTgl_r <= 1'b0;
    end else if (sclClk) begin
      startTgl_r <= ~startTgl_r;
    end
  end
  // [R02] Stop on rising data with clock high
  always_ff @(posedge sdaIn or negedge rst_n) begin
    if (!rst_n) begin
      stopTgl_r <= 1'b0;
    end else if (sclClk) begin
      stopTgl_r <= ~stopTgl_r;
    end
  end
  // Link side compares toggles against last seen copies
  logic startLast_r, stopLast_r;
  logic startEv, stopEv;
  assign startEv = startTgl_r != startLast_r;
  assign stopEv = stopTgl_r != stopLast_r;

  // ---------------------------------------------------------------
  // Bit engine on the link clock
  // ---------------------------------------------------------------
  eeprom_pkg::phase_t phase_r, phase_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  eeprom_pkg::byte_t shift_r, shift_nxt;
  logic readDir_r, readDir_nxt;
  logic ackDrive_r, ackDrive_nxt;
  logic [7:0] wordAddr_r, wordAddr_nxt;
  logic [3:0] pageCnt_r, pageCnt_nxt;
  logic pageWr_r, pageWr_nxt;
  logic bufWrite;
  // Byte being sent in a read, latched at the address ack and each master ack
  eeprom_pkg::byte_t txByte_r, txByte_nxt;
  // Write-busy level from the system domain, two flops
  logic busySync1_r, busySync2_r;
  // Straps and protect pass two flops on the link clock
  logic [3:0] strapSync1_r, strapSync2_r;
  logic [7:0] myAddr;
  logic [7:0] outByte;

  // [R14] [R16] Pulled-low inputs need no special case here
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      strapSync1_r <= 4'h0;
      strapSync2_r <= 4'h0;
      busySync1_r <= 1'b0;
      busySync2_r <= 1'b0;
    end else begin
      strapSync1_r <= {writeProtect, select_strap_high,
                       select_strap_mid, select_strap_low};
      strapSync2_r <= strapSync1_r;
      busySync1_r <= writeBusy;
      busySync2_r <= busySync1_r;
    end
  end
  // [R11] [R12] Expected address: class, straps high to low
  assign myAddr = {`CLASS_ID, strapSync2_r[2:0], 1'b0};

  // Memory carrier
  mem_if memBus ();
  byte_mem memInst (
    .clk(clk),
    .port(memBus)
  );

  // Page buffer lives on the link clock, small enough for flops
  logic [7:0] pageBuf_r [0:15];
  logic [15:0] pageValid_r;
  logic [7:0] pageBase_r, pageBase_nxt;

  // Next-state logic, evaluated on the clock rising edge
  // [R20] Link-clocked, so any bus rate up to fast mode works
  always_comb begin
    phase_nxt = phase_r;
    txByte_nxt = txByte_r;
    bitCnt_nxt = bitCnt_r + 4'h1;
    shift_nxt = {shift_r[6:0], sdaIn};
    readDir_nxt = readDir_r;
    wordAddr_nxt = wordAddr_r;
    pageCnt_nxt = pageCnt_r;
    pageWr_nxt = pageWr_r;
    bufWrite = 1'b0;
    if (startEv) begin
      // [R27] Start anywhere restarts address reception
      phase_nxt = eeprom_pkg::DEV_ADDR;
      bitCnt_nxt = 4'h1;
      shift_nxt = {7'h00, sdaIn};
    end else if (stopEv) begin
      // [R02] Stop returns to standby
      phase_nxt = eeprom_pkg::IDLE;
      bitCnt_nxt = 4'h0;
    end else if (phase_r == eeprom_pkg::IDLE ||
                 phase_r == eeprom_pkg::IGNORE) begin
      bitCnt_nxt = 4'h0;
    end else if (bitCnt_r == `ACK_SLOT) begin
      // Ninth clock: move on after the acknowledge slot
      bitCnt_nxt = 4'h0;
      unique case (phase_r)
        eeprom_pkg::DEV_ADDR: begin
          // [R26] [R08] Mismatch or busy: ignore till start
          if (shift_r[7:1] != myAddr[7:1] || busySync2_r) begin
            phase_nxt = eeprom_pkg::IGNORE;
          end else if (shift_r[0]) begin
            // [R13] One selects read
            phase_nxt = eeprom_pkg::RD_DATA;
            readDir_nxt = 1'b1;
            // Latch first byte, pointer moves past it at once
            txByte_nxt = outByte;
            wordAddr_nxt = wordAddr_r + 8'h01;
          end else begin
            phase_nxt = eeprom_pkg::WORD_ADDR;
            readDir_nxt = 1'b0;
          end
        end
        eeprom_pkg::WORD_ADDR: begin
          wordAddr_nxt = shift_r;
          pageCnt_nxt = 4'h0;
          phase_nxt = eeprom_pkg::WR_DATA;
        end
        eeprom_pkg::WR_DATA: begin
          // [R23] Protected data byte ends the write
          if (strapSync2_r[3]) begin
            phase_nxt = eeprom_pkg::IGNORE;
          end else begin
            // [R17] [R24] Buffer byte, page offset wraps
            bufWrite = 1'b1;
            pageWr_nxt = 1'b1;
            pageCnt_nxt = pageCnt_r + 4'h1;
            wordAddr_nxt = {wordAddr_r[7:4], wordAddr_r[3:0] + 4'h1};
          end
        end
        eeprom_pkg::RD_DATA: begin
          // [R09] [R10] Master ack continues, nack stops
          // Ack level is the pin itself at this ninth rising edge
          if (sdaIn) begin
            phase_nxt = eeprom_pkg::IGNORE;
          end else begin
            // [R18] [R25] Read pointer rolls over the array
            // Latching here leaves a whole byte for memory to settle
            txByte_nxt = outByte;
            wordAddr_nxt = wordAddr_r + 8'h01;
          end
        end
        default: phase_nxt = eeprom_pkg::IGNORE;
      endcase
    end
  end

  // Registered phase state, advance on clock rising edge
  // [R06] One clock pulse per bit
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= eeprom_pkg::IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      readDir_r <= 1'b0;
      wordAddr_r <= 8'h00;
      pageCnt_r <= 4'h0;
      startLast_r <= 1'b0;
      stopLast_r <= 1'b0;
      txByte_r <= 8'hFF;
    end else begin
      phase_r <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      readDir_r <= readDir_nxt;
      wordAddr_r <= wordAddr_nxt;
      pageCnt_r <= pageCnt_nxt;
      startLast_r <= startTgl_r;
      stopLast_r <= stopTgl_r;
      txByte_r <= txByte_nxt;
    end
  end
  // [R27] Start restarts address reception at bit one
  start_restart_a: assert property (@(posedge sclClk) disable iff (!rst_n) // [R27]
    startEv |=> phase_r == eeprom_pkg::DEV_ADDR && bitCnt_r == 4'h1)
    else $error("start did not restart address");
  // [R06] Bit counter never passes the ack slot
  bit_count_a: assert property (@(posedge sclClk) disable iff (!rst_n) // [R06]
    bitCnt_r <= `ACK_SLOT) else $error("bit counter overran");
  // [R15] No byte is buffered while protected
  protect_block_a: assert property (@(posedge sclClk) disable iff (!rst_n) // [R15]
    bufWrite |-> !strapSync2_r[3]) else $error("protected byte buffered");

  // Page contents, base address and pending flag
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      pageValid_r <= 16'h0000;
      pageWr_r <= 1'b0;
    end else begin
      pageWr_r <= pageWr_nxt;
      if (startEv || stopEv) begin
        pageWr_r <= 1'b0;
      end
      if (bufWrite) begin
        pageBuf_r[wordAddr_r[3:0]] <= shift_r;
        pageValid_r[wordAddr_r[3:0]] <= 1'b1;
        pageBase_r <= {wordAddr_r[7:4], 4'h0};
      end else if (phase_r == eeprom_pkg::WORD_ADDR) begin
        pageValid_r <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data pin drive, changed on the clock falling edge
  // ---------------------------------------------------------------
  // [R05] Launch only while clock is low
  assign outByte = memBus.rdData;
  always_comb begin
    ackDrive_nxt = 1'b0;
    if (bitCnt_r == `ACK_SLOT && !startEv && !stopEv) begin
      unique case (phase_r)
        eeprom_pkg::DEV_ADDR: ackDrive_nxt =
          shift_r[7:1] == myAddr[7:1] && !busySync2_r;
        eeprom_pkg::WORD_ADDR: ackDrive_nxt = 1'b1;
        eeprom_pkg::WR_DATA: ackDrive_nxt = !strapSync2_r[3];
        default: ackDrive_nxt = 1'b0;
      endcase
    end else if (phase_r == eeprom_pkg::RD_DATA && bitCnt_r < 4'h8) begin
      // [R04] MSB first out of the read byte
      ackDrive_nxt = !txByte_r[3'h7 - bitCnt_r[2:0]];
    end
  end
  // [R07] Acknowledge and read bits pulled low on falling edge
  always_ff @(negedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      ackDrive_r <= 1'b0;
    end else begin
      ackDrive_r <= ackDrive_nxt;
    end
  end
  // [R21] Only the data pin is ever driven
  assign sdaOut = 1'b0;
  assign sdaOe = ackDrive_r;
  // [R26] An ignored transfer never pulls the data line
  ignore_quiet_a: assert property (@(posedge sclClk) disable iff (!rst_n) // [R26]
    phase_r == eeprom_pkg::IGNORE |-> !ackDrive_nxt)
    else $error("data pulled while ignoring");

  // ---------------------------------------------------------------
  // Write cycle in the system domain
  // ---------------------------------------------------------------
  // Stop toggle crosses through two flops then edge detect
  logic stopSync1_r, stopSync2_r, stopSync3_r;
  logic commitReq;
  logic [19:0] waitCnt_r, waitCnt_nxt;
  logic [4:0] flushIdx_r, flushIdx_nxt;
  logic busy_r, busy_nxt;
  logic memWr;
  logic pendSync1_r, pendSync2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopSync1_r <= 1'b0;
      stopSync2_r <= 1'b0;
      stopSync3_r <= 1'b0;
      pendSync1_r <= 1'b0;
      pendSync2_r <= 1'b0;
    end else begin
      stopSync1_r <= stopTgl_r;
      stopSync2_r <= stopSync1_r;
      stopSync3_r <= stopSync2_r;
      pendSync1_r <= pageWr_r;
      pendSync2_r <= pendSync1_r;
    end
  end
  // [R22] Stop with a buffered page starts the cycle
  // Page data is static once the stop has frozen the link side.
  assign commitReq = (stopSync2_r != stopSync3_r) && pendSync2_r && !busy_r;

  always_comb begin
    busy_nxt = busy_r;
    waitCnt_nxt = waitCnt_r;
    flushIdx_nxt = flushIdx_r;
    memWr = 1'b0;
    if (commitReq) begin
      busy_nxt = 1'b1;
      waitCnt_nxt = 20'(WRITE_CYCLES);
      flushIdx_nxt = 5'h00;
    end else if (busy_r) begin
      if (flushIdx_r < 5'h10) begin
        memWr = pageValid_r[flushIdx_r[3:0]];
        flushIdx_nxt = flushIdx_r + 5'h01;
      end
      if (waitCnt_r != 20'h00000) begin
        waitCnt_nxt = waitCnt_r - 20'h00001;
      end else begin
        busy_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      waitCnt_r <= 20'h00000;
      flushIdx_r <= 5'h10;
    end else begin
      busy_r <= busy_nxt;
      waitCnt_r <= waitCnt_nxt;
      flushIdx_r <= flushIdx_nxt;
    end
  end
  // [R15] Protected transfers never fill the page, so no write
  assign memBus.wrEn = memWr;
  assign memBus.wrAddr = pageBase_r | {4'h0, flushIdx_r[3:0]};
  assign memBus.wrData = pageBuf_r[flushIdx_r[3:0]];
  assign memBus.rdAddr = wordAddr_r;
  assign writeBusy = busy_r;

  // Write cycle not cut short; busy must hold for eight clk cycles once raised
  busy_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
    $rose(busy_r) |-> busy_r [*8]) else $error("busy dropped early");
  // [R08] Busy ends when the timer runs out
  busy_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
    busy_r && waitCnt_r == 20'h00000 |=> !busy_r)
    else $error("busy stuck after timer");
  // [R22] Array writes only inside the write cycle
  flush_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
    memWr |-> busy_r) else $error("array write outside cycle");
endmodule

// File: testbench/eeprom_master.sv
// Two-wire bus master model for the EEPROM slave bench
module eeprom_master (
  // Bus clock, stands high between frames
  output logic scl,
  // Request to pull the data line low
  output logic sdaLow,
  // Resolved data line level
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------
  // Bus idle: clock high, data released
  // -----------------------------------------
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic start();
    sdaLow = 1'b0;
    #3 scl = 1'b1;
    #3 sdaLow = 1'b1;
    #3 scl = 1'b0;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    #3 scl = 1'b1;
    #3 sdaLow = 1'b0;
    #3;
  endtask

  task automatic xferBit(input logic b, output logic s);
    sdaLow = ~b;
    #3 scl = 1'b1;
    #1 s = sda;
    #2 scl = 1'b0;
  endtask

  // eight bits then release for ack
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xferBit(d[i], s);
    end
    xferBit(1'b1, s);
    ack = ~s;
  endtask

  // master acks in the ninth clock when ackIt is set, else nacks
  task automatic rdByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xferBit(1'b1, d[i]);
    end
    xferBit(~ackIt, s);
  endtask
endmodule

// File: testbench/serial_eeprom_i2c_slave_bench.sv
// Self-checking bench for the two-wire EEPROM slave
`include "eeprom_map.svh"
module serial_eeprom_i2c_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------
  // Signals
  // -----------------------------------------
  logic clk;
  logic rst_n;
  logic stLow, stMid, stHigh, wp;
  wire logic scl;
  wire logic mLow;
  wire logic sdaOut, sdaOe, writeBusy;
  // Pull-up wins unless someone pulls low
  wire logic sda = ~(mLow | (sdaOe & ~sdaOut));
  int fails = 0;
  int num_checks = 0;
  logic a;
  logic [7:0] d;
  // Straps high=1 mid=0 low=1 give device field 3'b101
  localparam logic [6:0] DEV = {`CLASS_ID, 3'b101};

  eeprom_master m (.scl(scl), .sdaLow(mLow), .sda(sda));

  // Short write cycle keeps the run brief
  serial_eeprom_i2c_slave #(.WRITE_CYCLES(50)) dut (
    .clk(clk), .rst_n(rst_n), .sclClk(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .select_strap_low(stLow),
    .select_strap_mid(stMid), .select_strap_high(stHigh),
    .writeProtect(wp), .writeBusy(writeBusy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -----------------------------------------
  // Shared helpers
  // -----------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait, the write timer is only 50 cycles
  task automatic waitBusy(input logic lvl);
    int n = 0;
    while (writeBusy !== lvl && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("writeBusy", {7'h0, writeBusy}, {7'h0, lvl});
  endtask

  // Start, write-direction address, word address
  task automatic setWord(input logic [7:0] w);
    m.start();
    m.wrByte({DEV, 1'b0}, a);
    check("dev ack", {7'h0, a}, 8'h01);
    m.wrByte(w, a);
    check("word ack", {7'h0, a}, 8'h01);
  endtask

  // Read n bytes from base, last one not acknowledged
  task automatic readSeq(input logic [7:0] w, input int n,
                         input logic [7:0] e0, input logic [7:0] e1,
                         input logic [7:0] e2);
    logic [7:0] e [3];
    e = '{e0, e1, e2};
    setWord(w);
    m.start();
    m.wrByte({DEV, 1'b1}, a);
    check("read ack", {7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rdByte(i < n - 1, d);
      check("read data", d, e[i]);
    end
  endtask

  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task automatic testWrite();
    setWord(8'h10);
    for (int i = 0; i < 4; i++) begin
      m.wrByte(8'hA0 + 8'(i), a);
      check("data ack", {7'h0, a}, 8'h01);
    end
    m.stop();
    waitBusy(1'b1);
    m.start();
    m.wrByte({DEV, 1'b0}, a);
    check("busy nack", {7'h0, a}, 8'h00);
    m.stop();
    waitBusy(1'b0);
    $display("test write done");
  endtask

  task automatic testRead();
    readSeq(8'h10, 3, 8'hA0, 8'hA1, 8'hA2);
    m.rdByte(1'b0, d);
    check("released", d, 8'hFF);
    m.stop();
    m.start();
    m.wrByte({DEV, 1'b1}, a);
    m.rdByte(1'b0, d);
    check("current read", d, 8'hA3);
    m.stop();
    $display("test read done");
  endtask

  task automatic testStraps();
    for (int k = 0; k < 8; k++) begin
      m.start();
      m.wrByte({`CLASS_ID, 3'(k), 1'b0}, a);
      check("strap ack", {7'h0, a}, {7'h0, k == 5});
      m.wrByte(8'h00, a);
      check("second ack", {7'h0, a}, {7'h0, k == 5});
      m.stop();
    end
    $display("test straps done");
  endtask

  task automatic testProtect();
    @(negedge clk);
    wp = 1'b1;
    setWord(8'h30);
    m.wrByte(8'h55, a);
    check("protect nack", {7'h0, a}, 8'h00);
    m.stop();
    repeat (20) @(posedge clk);
    check("no cycle", {7'h0, writeBusy}, 8'h00);
    @(negedge clk);
    wp = 1'b0;
    $display("test protect done");
  endtask

  task automatic testWrap();
    setWord(8'h20);
    for (int i = 0; i < 18; i++) begin
      m.wrByte(8'h40 + 8'(i), a);
    end
    m.stop();
    waitBusy(1'b1);
    waitBusy(1'b0);
    readSeq(8'h20, 3, 8'h50, 8'h51, 8'h42);
    m.stop();
    $display("test wrap done");
  endtask

  task automatic testAbort();
    logic s;
    m.start();
    for (int i = 0; i < 4; i++) begin
      m.xferBit(1'b1, s);
    end
    m.stop();
    m.start();
    m.wrByte({DEV, 1'b0}, a);
    check("after abort", {7'h0, a}, 8'h01);
    m.stop();
    $display("test abort done");
  endtask

  // -----------------------------------------
  // Verdict and run control
  // -----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected few microseconds of traffic
  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    stLow = 1'b1;
    stMid = 1'b0;
    stHigh = 1'b1;
    wp = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    testWrite();
    testRead();
    testStraps();
    testProtect();
    testWrap();
    testAbort();
    summarize();
  end
endmodule
